// ---- include/slave_port_pkg.sv ----
// constants for the slave host handshake port
// assumes a 100 MHz register clock and a 32-bit AXI4-Lite slave
package slave_port_pkg;
  localparam logic [7:0] OFF_INBOUND  = 8'h00;
  localparam logic [7:0] OFF_IN_DIR   = 8'h04;
  localparam logic [7:0] OFF_OUTBOUND = 8'h10;
  localparam logic [7:0] OFF_BUS_DIR  = 8'h14;
  localparam logic [7:0] OFF_HS_DATA  = 8'h18;
  localparam logic [7:0] OFF_HS_DIR   = 8'h1c;
  localparam logic [7:0] OFF_MODE     = 8'h2c;
  localparam logic [7:0] OFF_STATUS   = 8'h30;

  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic       RST_MODE     = 1'b0;
  localparam logic       RST_READY_N  = 1'b1;

  localparam int WR_TRIG_BIT = 0;
  localparam int RD_TRIG_BIT = 1;
  localparam int STB_BIT     = 2;
  localparam int DIR_BIT     = 3;
  localparam int MODE_BIT    = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_NS     = 10;
  localparam int T_SO_NS    = 75;
  // longest time rounds down
  localparam int SO_MAX_CYC = T_SO_NS / CLK_NS;
endpackage : slave_port_pkg

// ---- logic/pin_sync.sv ----
// two-flop synchroniser for the strobe and direction pins
// assumes pins are steady for several clocks around each edge
`timescale 1ns/1ns
module pin_sync (
  input  wire logic       mclk_in,  // clock
  input  wire logic       rst_in,   // sync reset, high
  input  wire logic [1:0] pins_in,  // {direction, strobe}
  output logic      [1:0] pins_out  // synchronised copy
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
    end
  end

  assign pins_out = sync_q;
endmodule : pin_sync

// ---- logic/slave_host_port.sv ----
// slave host handshake port with AXI4-Lite register access
// assumes host keeps strobe high through init and drives
// strobe and direction per the handshake sequence
// Overview of operation
// - reset release leaves both ready outputs high
// - firmware clears data registers before transfers
// - firmware sets bus and ready pins outputs
// - inbound port and strobe, direction stay inputs
// - lowering a ready output announces readiness
// - starts slave mode; mode bit selects master
// - trigger bit 0 falling drops write ready
// - strobe rise captures byte, raises write ready
// - write done interrupt as write ready rises
// - firmware reads captured byte from inbound port
// - trigger bit 1 falling drops read ready
// - outbound byte driven while read strobe low
// - strobe rise raises read ready and interrupt
// - read ready high within 75 ns of strobe
// - port D bits map ready, strobe, direction, spare
// - inbound port mirrors host bus pins in master mode
// - mode bit access raises no interrupt
`timescale 1ns/1ns
module slave_host_port (
  input  wire logic        mclk_in,             // clock 100 MHz
  input  wire logic        rst_in,              // sync reset, high
  input  wire logic [7:0]  awaddr_in,           // write address
  input  wire logic        awvalid_in,          // write addr valid
  output logic             awready_out,         // write addr ready
  input  wire logic [31:0] wdata_in,            // write data
  input  wire logic [3:0]  wstrb_in,            // byte enables
  input  wire logic        wvalid_in,           // write data valid
  output logic             wready_out,          // write data ready
  output logic [1:0]       bresp_out,           // write response
  output logic             bvalid_out,          // response valid
  input  wire logic        bready_in,           // response ready
  input  wire logic [7:0]  araddr_in,           // read address
  input  wire logic        arvalid_in,          // read addr valid
  output logic             arready_out,         // read addr ready
  output logic [31:0]      rdata_out,           // read data
  output logic [1:0]       rresp_out,           // read response
  output logic             rvalid_out,          // read data valid
  input  wire logic        rready_in,           // read data ready
  input  wire logic [7:0]  host_bus_pins_in,    // bus pin level
  output logic [7:0]       host_bus_pins_out,   // bus drive value
  output logic [7:0]       host_bus_pins_oe,    // bus drive enable
  input  wire logic [7:0]  hs_pins_in,          // port D pin level
  output logic [7:0]       hs_pins_out,         // port D drive
  output logic [7:0]       hs_pins_oe,          // port D enable
  output logic             write_done_irq_out,  // host write done
  output logic             read_done_irq_out    // host read done
);
  logic [7:0]  aw_addr_q;
  logic        aw_full_q;
  logic [31:0] w_data_q;
  logic        w_strb_q;
  logic        w_full_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        do_write;
  logic        do_read;

  logic [7:0]  in_dir_q;
  logic [7:0]  outbound_q;
  logic [7:0]  bus_dir_q;
  logic [7:0]  hs_data_q;
  logic [7:0]  hs_dir_q;
  logic        master_mode_q;
  logic [7:0]  inbound_q;
  logic [1:0]  trig_prev_q;
  logic        wr_rdy_n_q;
  logic        rd_rdy_n_q;
  logic        wr_irq_q;
  logic        rd_irq_q;

  logic [1:0]  pins_sync;
  logic        stb_s;
  logic        rw_s;
  logic        stb_d_q;
  logic        stb_rise;
  logic        slave_mode;
  logic        wr_arm;
  logic        rd_arm;
  logic        wr_done;
  logic        rd_done;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == slave_port_pkg::OFF_INBOUND)  ||
             (a == slave_port_pkg::OFF_IN_DIR)   ||
             (a == slave_port_pkg::OFF_OUTBOUND) ||
             (a == slave_port_pkg::OFF_BUS_DIR)  ||
             (a == slave_port_pkg::OFF_HS_DATA)  ||
             (a == slave_port_pkg::OFF_HS_DIR)   ||
             (a == slave_port_pkg::OFF_MODE)     ||
             (a == slave_port_pkg::OFF_STATUS);
  endfunction : mapped

  // axi write channels, taken in either order
  assign awready_out = !aw_full_q && !bvalid_q;
  assign wready_out  = !w_full_q && !bvalid_q;
  assign do_write    = aw_full_q && w_full_q && !bvalid_q;
  assign bvalid_out  = bvalid_q;
  assign bresp_out   = bresp_q;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid_in && awready_out) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= awaddr_in;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 1'b0;
    end else if (wvalid_in && wready_out) begin
      w_full_q <= 1'b1;
      w_data_q <= wdata_in;
      w_strb_q <= wstrb_in[0];
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      bvalid_q <= 1'b0;
      bresp_q  <= slave_port_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= mapped(aw_addr_q) ? slave_port_pkg::RESP_OKAY
                                    : slave_port_pkg::RESP_SLVERR;
    end else if (bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  // register writes; only the low byte lane carries data
  // data registers reset and clear to zero
  // firmware sets bus direction; slave mode forces the ready pin enables
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      in_dir_q   <= slave_port_pkg::RST_BYTE;
      outbound_q <= slave_port_pkg::RST_BYTE;
      bus_dir_q  <= slave_port_pkg::RST_BYTE;
      hs_data_q  <= slave_port_pkg::RST_BYTE;
      hs_dir_q   <= slave_port_pkg::RST_BYTE;
    end else if (do_write && w_strb_q) begin
      unique case (aw_addr_q)
        slave_port_pkg::OFF_IN_DIR:   in_dir_q   <= w_data_q[7:0];
        slave_port_pkg::OFF_OUTBOUND: outbound_q <= w_data_q[7:0];
        slave_port_pkg::OFF_BUS_DIR:  bus_dir_q  <= w_data_q[7:0];
        slave_port_pkg::OFF_HS_DATA:  hs_data_q  <= w_data_q[7:0];
        slave_port_pkg::OFF_HS_DIR:   hs_dir_q   <= w_data_q[7:0];
        default: ;
      endcase
    end
  end

  // slave after reset, mode bit selects master
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      master_mode_q <= slave_port_pkg::RST_MODE;
    end else if (do_write && w_strb_q &&
                 aw_addr_q == slave_port_pkg::OFF_MODE) begin
      master_mode_q <= w_data_q[slave_port_pkg::MODE_BIT];
    end
  end

  assign slave_mode = !master_mode_q;

  // axi read; data registered, one read in flight
  assign arready_out = !rvalid_q;
  assign do_read     = arvalid_in && arready_out;
  assign rvalid_out  = rvalid_q;
  assign rdata_out   = rdata_q;
  assign rresp_out   = rresp_q;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rvalid_q <= 1'b0;
      rresp_q  <= slave_port_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (do_read) begin
      rvalid_q <= 1'b1;
      rresp_q  <= mapped(araddr_in) ? slave_port_pkg::RESP_OKAY
                                    : slave_port_pkg::RESP_SLVERR;
      rdata_q  <= 32'h0000_0000;
      unique case (araddr_in)
        // captured byte; live bus in master
        slave_port_pkg::OFF_INBOUND:
          rdata_q[7:0] <= slave_mode ? inbound_q : host_bus_pins_in;
        slave_port_pkg::OFF_IN_DIR:   rdata_q[7:0] <= in_dir_q;
        slave_port_pkg::OFF_OUTBOUND: rdata_q[7:0] <= outbound_q;
        slave_port_pkg::OFF_BUS_DIR:  rdata_q[7:0] <= bus_dir_q;
        slave_port_pkg::OFF_HS_DATA:  rdata_q[7:0] <= hs_data_q;
        slave_port_pkg::OFF_HS_DIR:   rdata_q[7:0] <= hs_dir_q;
        slave_port_pkg::OFF_MODE:     rdata_q[0]   <= master_mode_q;
        slave_port_pkg::OFF_STATUS:
          rdata_q[2:0] <= {master_mode_q, rd_rdy_n_q, wr_rdy_n_q};
        default: ;
      endcase
    end else if (rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  // host pins pass two flops before any edge logic
  pin_sync u_pin_sync (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .pins_in  ({hs_pins_in[slave_port_pkg::DIR_BIT],
                hs_pins_in[slave_port_pkg::STB_BIT]}),
    .pins_out (pins_sync)
  );

  assign stb_s = pins_sync[0];
  assign rw_s  = pins_sync[1];

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      stb_d_q     <= 1'b1;
      trig_prev_q <= 2'h0;
    end else begin
      stb_d_q     <= stb_s;
      trig_prev_q <= {hs_data_q[slave_port_pkg::RD_TRIG_BIT],
                      hs_data_q[slave_port_pkg::WR_TRIG_BIT]};
    end
  end

  assign stb_rise = stb_s && !stb_d_q;
  // falling edge of the low-high-low trigger pulses
  assign wr_arm = slave_mode && trig_prev_q[0] &&
                  !hs_data_q[slave_port_pkg::WR_TRIG_BIT];
  assign rd_arm = slave_mode && trig_prev_q[1] &&
                  !hs_data_q[slave_port_pkg::RD_TRIG_BIT];
  // strobe edges only count while the matching ready is low
  assign wr_done = slave_mode && stb_rise && !rw_s && !wr_rdy_n_q;
  assign rd_done = slave_mode && stb_rise && rw_s && !rd_rdy_n_q;

  // ready high out of reset; low when armed
  // write ready falls on arm, rises on strobe
  always_ff @(posedge mclk_in) begin
    if (rst_in || master_mode_q) begin
      wr_rdy_n_q <= slave_port_pkg::RST_READY_N;
    end else if (wr_arm) begin
      wr_rdy_n_q <= 1'b0;
    end else if (wr_done) begin
      wr_rdy_n_q <= 1'b1;
    end
  end

  // read ready falls on arm, rises on strobe
  // rise three clocks after the pin edge
  always_ff @(posedge mclk_in) begin
    if (rst_in || master_mode_q) begin
      rd_rdy_n_q <= slave_port_pkg::RST_READY_N;
    end else if (rd_arm) begin
      rd_rdy_n_q <= 1'b0;
    end else if (rd_done) begin
      rd_rdy_n_q <= 1'b1;
    end
  end

  // bus byte latched at strobe rise
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      inbound_q <= slave_port_pkg::RST_BYTE;
    end else if (wr_done) begin
      inbound_q <= host_bus_pins_in;
    end
  end

  // mode register access never reaches these
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wr_irq_q <= 1'b0;
      rd_irq_q <= 1'b0;
    end else begin
      wr_irq_q <= wr_done;
      rd_irq_q <= rd_done;
    end
  end

  assign write_done_irq_out = wr_irq_q;
  assign read_done_irq_out  = rd_irq_q;

  // slave remaps port D low nibble
  always_comb begin
    hs_pins_out = hs_data_q;
    hs_pins_oe  = hs_dir_q;
    if (slave_mode) begin
      hs_pins_out[3:0] = {2'h0, rd_rdy_n_q, wr_rdy_n_q};
      hs_pins_oe[3:0]  = 4'h3;
    end
  end

  // in slave mode drive only while a read strobe is low, so the
  // host owns the bus for writes despite the 0xff direction
  assign host_bus_pins_out = outbound_q;
  assign host_bus_pins_oe  = slave_mode ?
                             (bus_dir_q & {8{rw_s && !stb_s}}) :
                             bus_dir_q;

  localparam int so_max_c = slave_port_pkg::SO_MAX_CYC;

  chk_reset_ready: assert property (@(posedge mclk_in)
    rst_in |=> wr_rdy_n_q && rd_rdy_n_q)
    else $error("ready outputs not high after reset");

  chk_mode_reset: assert property (@(posedge mclk_in)
    rst_in |=> !master_mode_q)
    else $error("device not in slave mode after reset");

  chk_write_arm: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    wr_arm |=> !hs_pins_out[0] ##1 !hs_pins_out[0] || wr_done)
    else $error("write ready not low after trigger");

  chk_write_latch: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    wr_done |=> inbound_q == $past(host_bus_pins_in) && wr_rdy_n_q)
    else $error("host byte not latched on strobe rise");

  chk_write_irq: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    $rose(wr_rdy_n_q) && slave_mode |-> write_done_irq_out)
    else $error("no write interrupt as ready rises");

  chk_read_irq: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    $rose(rd_rdy_n_q) && slave_mode |-> read_done_irq_out)
    else $error("no read interrupt as ready rises");

  chk_read_ready_time: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    $rose(hs_pins_in[2]) && hs_pins_in[3] && !rd_rdy_n_q &&
    slave_mode && !rd_arm && !$past(rd_arm)
    |-> ##[1:so_max_c] hs_pins_out[1])
    else $error("read ready late after strobe rise");

  chk_bus_drive: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    slave_mode && rw_s && !stb_s && bus_dir_q == 8'hff
    |-> host_bus_pins_oe == 8'hff &&
        host_bus_pins_out == outbound_q)
    else $error("outbound byte not driven during read");

  chk_pin_roles: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    slave_mode |-> hs_pins_oe[3:0] == 4'h3 &&
                   hs_pins_out[1:0] == {rd_rdy_n_q, wr_rdy_n_q})
    else $error("port D roles wrong in slave mode");

  chk_mode_no_irq: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    !stb_rise |=> !write_done_irq_out && !read_done_irq_out)
    else $error("interrupt without strobe edge");

  cov_write_xfer: cover property (@(posedge mclk_in)
    disable iff (rst_in) wr_done);
  cov_read_xfer: cover property (@(posedge mclk_in)
    disable iff (rst_in) rd_done);
  cov_master_mode: cover property (@(posedge mclk_in)
    disable iff (rst_in) $rose(master_mode_q));
endmodule : slave_host_port

// ---- tb/host_mcu_model.sv ----
// behavioural host microcontroller for the slave handshake port
// assumes ready pins come from the device, bus resolved by the bench
`timescale 1ns/1ns
module host_mcu_model (
  input  wire logic       mclk_in,       // bench clock
  input  wire logic [1:0] ready_n_in,    // {read, write} ready pins
  input  wire logic [7:0] bus_in,        // resolved bus level
  output logic            strobe_n_out,  // strobe pin, low active
  output logic            rw_out,        // 1 read, 0 write
  output logic [7:0]      drive_out,     // bus drive value
  output logic            drive_oe_out,  // bus drive enable
  output logic [7:0]      got_out,       // byte taken on a read
  output logic            got_valid_out  // one-cycle capture pulse
);
  initial begin
    strobe_n_out = 1'b1;
    rw_out = 1'b0;
    drive_out = 8'h00;
    drive_oe_out = 1'b0;
    got_out = 8'h00;
    got_valid_out = 1'b0;
  end

  // wait past ready low, slack makes a slow host
  task automatic wait_ready(input int bit_idx, input int slack);
    do @(posedge mclk_in); while (ready_n_in[bit_idx] !== 1'b0);
    repeat (slack + 1) @(posedge mclk_in);
  endtask : wait_ready

  // direction low, strobe low, data, strobe high
  task automatic host_write(input logic [7:0] byte_in, input int slack);
    wait_ready(0, slack);
    rw_out <= 1'b0;
    repeat (8) @(posedge mclk_in);
    strobe_n_out <= 1'b0;
    drive_out <= byte_in;
    drive_oe_out <= 1'b1;
    repeat (11) @(posedge mclk_in);
    strobe_n_out <= 1'b1;
    // data hold of 90 ns past the rise
    repeat (9) @(posedge mclk_in);
    drive_oe_out <= 1'b0;
  endtask : host_write

  // direction high, strobe low, capture, then rise
  task automatic host_read(input int slack);
    wait_ready(1, slack);
    rw_out <= 1'b1;
    repeat (8) @(posedge mclk_in);
    strobe_n_out <= 1'b0;
    repeat (11) @(posedge mclk_in);
    got_out <= bus_in;
    got_valid_out <= 1'b1;
    @(posedge mclk_in);
    got_valid_out <= 1'b0;
    strobe_n_out <= 1'b1;
    repeat (3) @(posedge mclk_in);
  endtask : host_read
endmodule : host_mcu_model

// ---- tb/tb_slave_host_port.sv ----
// self-checking bench for the slave host handshake port
// assumes the host model above and an AXI4-Lite master built here
`timescale 1ns/1ns
module tb_slave_host_port;
  localparam logic [1:0] OK = slave_port_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = slave_port_pkg::RESP_SLVERR;
  logic        mclk_in, rst_in, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, wirq, rirq;
  logic        h_stb, h_rw, h_oe, h_got_v, stb_prev;
  logic [7:0]  awaddr, araddr, bus_out, bus_oe, hs_out, hs_oe;
  logic [7:0]  bus_w, bus_last, hs_w, h_drv, h_got, b;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  spare;
  logic [33:0] rd_q[$];
  logic [1:0]  b_q[$];
  logic [7:0]  hb_q[$];
  int          fail_count, n_compared, cyc, wr_irqs, rd_irqs, lat, seed;

  // released bus lines show the inverse of their last level
  assign bus_w = (bus_oe & bus_out) | (~bus_oe & (h_oe ? h_drv : ~bus_last));
  assign hs_w = (hs_oe & hs_out) |
                (~hs_oe & {spare, h_rw, h_stb, ~hs_out[1:0]});

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  slave_host_port u_slave_host_port (
    .mclk_in(mclk_in), .rst_in(rst_in), .awaddr_in(awaddr),
    .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata),
    .wstrb_in(4'hf), .wvalid_in(wvalid), .wready_out(wready),
    .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
    .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
    .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
    .rready_in(rready), .host_bus_pins_in(bus_w),
    .host_bus_pins_out(bus_out), .host_bus_pins_oe(bus_oe),
    .hs_pins_in(hs_w), .hs_pins_out(hs_out), .hs_pins_oe(hs_oe),
    .write_done_irq_out(wirq), .read_done_irq_out(rirq));

  host_mcu_model u_host_mcu_model (
    .mclk_in(mclk_in), .ready_n_in(hs_w[1:0]), .bus_in(bus_w),
    .strobe_n_out(h_stb), .rw_out(h_rw), .drive_out(h_drv),
    .drive_oe_out(h_oe), .got_out(h_got), .got_valid_out(h_got_v));

  task automatic check_data(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : check_data

  task automatic check_resp(input string n, input logic [1:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : check_resp

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge mclk_in);
    b_q.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    @(posedge mclk_in);
    rd_q.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : axi_rd

  // low-high-low pulse on one trigger bit
  task automatic arm(input int t);
    axi_wr(slave_port_pkg::OFF_HS_DATA, 32'h1 << t, OK);
    axi_wr(slave_port_pkg::OFF_HS_DATA, 32'h0, OK);
  endtask : arm

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  always @(posedge mclk_in) begin
    // undriven lines keep the inverse of the last driven level
    if (h_oe || |bus_oe) bus_last <= bus_w;
    cyc++;
    if (rvalid && rready) begin
      // expectations noted by axi_rd, oldest first
      check_data("rdata", rd_q.size() ? rd_q[0][31:0] : 'x, rdata);
      check_resp("rresp", rd_q.size() ? rd_q[0][33:32] : 'x, rresp);
      if (rd_q.size()) void'(rd_q.pop_front());
    end
    if (bvalid && bready)
      check_resp("bresp", b_q.size() ? b_q.pop_front() : 'x, bresp);
    if (h_got_v) check_data("host_byte",
      hb_q.size() ? hb_q.pop_front() : 'x, {24'h0, h_got});
    if (hs_w[2] && !stb_prev) lat = 0;
    else if (lat < 255) lat++;
    stb_prev = hs_w[2];
    if (wirq) begin
      wr_irqs++;
      check_data("write_ready_at_irq", 1, hs_out[0]);
    end
    if (rirq) begin
      rd_irqs++;
      check_data("read_ready_at_irq", 1, hs_out[1]);
      check_data("read_ready_delay", 1,
        lat + 1 <= slave_port_pkg::SO_MAX_CYC);
    end
    if (cyc == 6000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    seed = 28;
    rst_in = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, spare, bus_last} = '0;
    {cyc, fail_count, n_compared, wr_irqs, rd_irqs, lat} = '0;
    stb_prev = 1'b1;
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(negedge mclk_in);
    check_data("ready_pins", 32'h3, {30'h0, hs_out[1:0]});
    check_data("ready_oe", 32'h3, {30'h0, hs_oe[1:0]});
    check_data("bus_oe", 32'h0, {24'h0, bus_oe});
    axi_rd(slave_port_pkg::OFF_INBOUND, 32'h0, OK);
    axi_rd(slave_port_pkg::OFF_IN_DIR, 32'h0, OK);
    axi_rd(slave_port_pkg::OFF_OUTBOUND, 32'h0, OK);
    axi_rd(slave_port_pkg::OFF_HS_DATA, 32'h0, OK);
    axi_rd(slave_port_pkg::OFF_MODE, 32'h0, OK);
    axi_rd(slave_port_pkg::OFF_STATUS, 32'h3, OK);
    axi_wr(slave_port_pkg::OFF_BUS_DIR, 32'hff, OK);
    axi_wr(slave_port_pkg::OFF_HS_DIR, 32'h3, OK);
    axi_wr(slave_port_pkg::OFF_IN_DIR, 32'h0, OK);
    axi_rd(slave_port_pkg::OFF_BUS_DIR, 32'hff, OK);
    axi_rd(slave_port_pkg::OFF_HS_DIR, 32'h3, OK);
    check_data("hs_oe_low", 32'h3, {28'h0, hs_oe[3:0]});
    axi_wr(8'h40, 32'h5a, ERR);
    axi_rd(8'h40, 32'h0, ERR);
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      spare <= 4'($random(seed));
      arm(slave_port_pkg::WR_TRIG_BIT);
      axi_rd(slave_port_pkg::OFF_STATUS, 32'h2, OK);
      u_host_mcu_model.host_write(b, i * 3);
      axi_rd(slave_port_pkg::OFF_STATUS, 32'h3, OK);
      axi_rd(slave_port_pkg::OFF_INBOUND, {24'h0, b}, OK);
    end
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      axi_wr(slave_port_pkg::OFF_OUTBOUND, {24'h0, b}, OK);
      hb_q.push_back(b);
      arm(slave_port_pkg::RD_TRIG_BIT);
      axi_rd(slave_port_pkg::OFF_STATUS, 32'h1, OK);
      u_host_mcu_model.host_read(i * 2);
      axi_rd(slave_port_pkg::OFF_STATUS, 32'h3, OK);
    end
    check_data("write_irqs", 3, wr_irqs);
    check_data("read_irqs", 3, rd_irqs);
    axi_wr(slave_port_pkg::OFF_MODE, 32'h1, OK);
    axi_rd(slave_port_pkg::OFF_MODE, 32'h1, OK);
    // bus driven from the outbound byte, read back through inbound
    axi_rd(slave_port_pkg::OFF_INBOUND, {24'h0, b}, OK);
    arm(slave_port_pkg::WR_TRIG_BIT);
    axi_rd(slave_port_pkg::OFF_STATUS, 32'h7, OK);
    axi_wr(slave_port_pkg::OFF_MODE, 32'h0, OK);
    axi_rd(slave_port_pkg::OFF_STATUS, 32'h3, OK);
    repeat (8) @(posedge mclk_in);
    check_data("irqs_after_mode", 6, wr_irqs + rd_irqs);
    complete_run();
  end
endmodule : tb_slave_host_port
